// File: src/ert_pkg.sv
/*
 * Constants for the event/reload timer: register indices, field positions,
 * reset values, divider taps and timing counts.
 * Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none

package ert_pkg;

    // =====================================================================
    // Register indices; byte address is four times the index
    // =====================================================================
    localparam logic [7:0] IDX_OVF_FLAG = 8'h02;
    localparam logic [7:0] IDX_MODE_SEL = 8'h09;
    localparam logic [7:0] IDX_NIB_LOW = 8'h0a;
    localparam logic [7:0] IDX_NIB_HIGH = 8'h0b;
    localparam logic [7:0] IDX_PIN_SEL = 8'h24;
    localparam logic [7:0] IDX_EDGE_SEL = 8'h26;

    // =====================================================================
    // Field positions and reset values
    // =====================================================================
    localparam int MODE_RELOAD_BIT = 3;
    localparam logic [2:0] MODE_CLK_EXT = 3'h7;
    localparam int PIN_STOP_CANCEL_INPUT_BIT = 3;
    localparam int PIN_EVENT_BIT = 0;
    localparam int OVF_FLAG_BIT = 0;
    localparam logic [3:0] MODE_SEL_RST = 4'h0;
    localparam logic [1:0] EDGE_SEL_RST = 2'h0;
    localparam logic [3:0] NIB_LOW_RST = 4'h0;
    localparam logic [3:0] PIN_SEL_RST = 4'h0;
    localparam logic [10:0] DIV_RST = 11'h000;

    // Edge select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // =====================================================================
    // Divider taps: clock code n ticks once per 2**(tap+1) system clocks
    // =====================================================================
    localparam int DIV_W = 11;
    localparam logic [3:0] DIV_TAP [0:6] = '{4'ha, 4'h9, 4'h8, 4'h6, 4'h4, 4'h2, 4'h1};

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_PERIOD_NS = 25;
    localparam int INSN_CYCLE_NS = 1000;
    localparam int MODE_DELAY_INSN = 2;
    // Least time, rounded up
    localparam int MODE_DELAY_CYC =
        (MODE_DELAY_INSN * INSN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ert_pkg

`default_nettype wire

// File: src/ert_divider.sv
/*
 * Free-running clock divider chain and tick generator for the timer.
 * Assumes an asynchronous active-low reset already released cleanly.
 */
`timescale 1ns/10ps
`default_nettype none

module ert_divider #(
    parameter int WIDTH = ert_pkg::DIV_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic halt_in,
    input wire logic [2:0] sel_in,
    output logic tick_out
);

    initial
    begin
        if (WIDTH < 11)
            $error("ert_divider: WIDTH must be at least 11");
    end

    logic [WIDTH-1:0] clock_divider_chain_q;

    // Tick when every bit up to the tap is one, i.e. the tap is about to carry
    function automatic logic tap_carry(input logic [WIDTH-1:0] v, input logic [3:0] tap);
        logic r;
        r = 1'b1;
        for (int i = 0; i < WIDTH; i++)
            if (i <= int'(tap))
                r = r & v[i];
        return r;
    endfunction : tap_carry

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            clock_divider_chain_q <= WIDTH'(ert_pkg::DIV_RST);
        else if (!halt_in)
            clock_divider_chain_q <= clock_divider_chain_q + WIDTH'(1);
    end

    always_comb
    begin
        if (halt_in || sel_in == ert_pkg::MODE_CLK_EXT)
            tick_out = 1'b0;
        else
            tick_out = tap_carry(clock_divider_chain_q, ert_pkg::DIV_TAP[sel_in]);
    end

endmodule : ert_divider

`default_nettype wire

// File: src/ert_edge_detect.sv
/*
 * Edge detector for the event count input.
 * Assumes the pin is already synchronous to the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module ert_edge_detect (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    input wire logic enable_in,
    input wire logic [1:0] edge_sel_in,
    output logic pulse_out
);

    logic prev_q;
    logic rise;
    logic fall;

    // Sampled once per system clock so one edge yields one pulse
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            prev_q <= 1'b0;
        else
            prev_q <= pin_in;
    end

    assign rise = pin_in & ~prev_q;
    assign fall = ~pin_in & prev_q;

    always_comb
    begin
        pulse_out = 1'b0;
        if (enable_in)
        begin
            unique case (edge_sel_in)
                ert_pkg::EDGE_NONE: pulse_out = 1'b0;
                ert_pkg::EDGE_RISE: pulse_out = rise;
                ert_pkg::EDGE_FALL: pulse_out = fall;
                ert_pkg::EDGE_BOTH: pulse_out = rise | fall;
            endcase
        end
    end

endmodule : ert_edge_detect

`default_nettype wire

// File: src/ert_timer.sv
/*
 * 8-bit event/reload timer with prescaler and AXI4-Lite register slave.
 * Assumes inputs synchronous to clk_sys_in and a bus master that keeps
 * at most one read and one write outstanding.
 */
// Added by the designer: register access over AXI4-Lite.
// Summary of operation
// - 11-bit prescaler supplies timer clock choices
// - Reset clears prescaler; restarts after release
// - Prescaler halts only in reset or stop
// - 8-bit counter: free, reload, event modes
// - Mode one picks reload and count clock
// - Increment per clock; all-ones wraps overflow
// - Overflow reloads preload or restarts zero
// - Overflow sets flag; software write clears
// - Event mode counts chosen pin edges
// - Mode one resets zero, applies after delay
// - Edge select two bits, resets zero
// - Low preload nibble resets zero
// - Low nibble write leaves counter unchanged
// - High nibble write loads whole counter
// - High-only write reuses stored low nibble
// - Pin select bits 3 and 0 route pins
// - High read latches low for later
`timescale 1ns/10ps
`default_nettype none

module ert_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic stop_mode_in,
    input wire logic event_count_input_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic overflow_request_flag_out,
    output logic stop_cancel_pin_select_out,
    output logic event_pin_select_out
);

    initial
    begin
        if (ADDR_W < 8 || ADDR_W > 32)
            $error("ert_timer: ADDR_W must be 8 to 32");
    end

    // =====================================================================
    // Reset release
    // =====================================================================
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // Register index from a byte address; low two bits ignored
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] s;
        s = a >> 2;
        if (|(s >> 8))
            return 8'hff;
        return s[7:0];
    endfunction : reg_index

    // =====================================================================
    // Write channel
    // =====================================================================
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] wr_idx_q;
    logic [3:0] wr_nib_q;
    logic wr_lane_q;
    logic wr_fire;
    logic wr_mapped;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
    assign wr_mapped = wr_idx_q == ert_pkg::IDX_OVF_FLAG || wr_idx_q == ert_pkg::IDX_MODE_SEL ||
                       wr_idx_q == ert_pkg::IDX_NIB_LOW || wr_idx_q == ert_pkg::IDX_NIB_HIGH ||
                       wr_idx_q == ert_pkg::IDX_PIN_SEL || wr_idx_q == ert_pkg::IDX_EDGE_SEL;

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_have_q <= 1'b0;
            s_axi_awready_out <= 1'b0;
            wr_idx_q <= 8'h00;
        end
        else if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            aw_have_q <= 1'b1;
            s_axi_awready_out <= 1'b0;
            wr_idx_q <= reg_index(s_axi_awaddr_in);
        end
        else if (s_axi_bvalid_out && s_axi_bready_in)
        begin
            aw_have_q <= 1'b0;
            s_axi_awready_out <= 1'b1;
        end
        else if (!aw_have_q && !s_axi_bvalid_out)
            s_axi_awready_out <= 1'b1;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_have_q <= 1'b0;
            s_axi_wready_out <= 1'b0;
            wr_nib_q <= 4'h0;
            wr_lane_q <= 1'b0;
        end
        else if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            w_have_q <= 1'b1;
            s_axi_wready_out <= 1'b0;
            wr_nib_q <= s_axi_wdata_in[3:0];
            wr_lane_q <= s_axi_wstrb_in[0];
        end
        else if (s_axi_bvalid_out && s_axi_bready_in)
        begin
            w_have_q <= 1'b0;
            s_axi_wready_out <= 1'b1;
        end
        else if (!w_have_q && !s_axi_bvalid_out)
            s_axi_wready_out <= 1'b1;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= ert_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_mapped ? ert_pkg::RESP_OKAY : ert_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
    end

    // Byte lane 0 carries every nibble; writes without it store nothing
    logic wr_en;
    assign wr_en = wr_fire && wr_lane_q;

    // =====================================================================
    // Software registers
    // =====================================================================
    logic [3:0] mode_pending_q;
    logic [3:0] count_mode_select_q;
    logic [6:0] mode_delay_q;
    logic mode_wait_q;
    logic [1:0] event_edge_select_q;
    logic [3:0] preload_low_nibble_q;
    logic [3:0] preload_high_nibble_q;
    logic [3:0] shared_pin_function_select_q;

    localparam logic [6:0] MODE_DELAY = 7'(ert_pkg::MODE_DELAY_CYC);

    // New mode only steers the counter once the delay runs out
    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_pending_q <= ert_pkg::MODE_SEL_RST;
            count_mode_select_q <= ert_pkg::MODE_SEL_RST;
            mode_delay_q <= 7'h00;
            mode_wait_q <= 1'b0;
        end
        else if (wr_en && wr_idx_q == ert_pkg::IDX_MODE_SEL)
        begin
            mode_pending_q <= wr_nib_q;
            mode_delay_q <= MODE_DELAY - 7'h01;
            mode_wait_q <= 1'b1;
        end
        else if (mode_wait_q)
        begin
            if (mode_delay_q == 7'h00)
            begin
                count_mode_select_q <= mode_pending_q;
                mode_wait_q <= 1'b0;
            end
            else
                mode_delay_q <= mode_delay_q - 7'h01;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
            event_edge_select_q <= ert_pkg::EDGE_SEL_RST;
        else if (wr_en && wr_idx_q == ert_pkg::IDX_EDGE_SEL)
            event_edge_select_q <= wr_nib_q[1:0];
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
            preload_low_nibble_q <= ert_pkg::NIB_LOW_RST;
        else if (wr_en && wr_idx_q == ert_pkg::IDX_NIB_LOW)
            preload_low_nibble_q <= wr_nib_q;
    end

    // High nibble has no defined reset value, so it is left unreset
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_en && wr_idx_q == ert_pkg::IDX_NIB_HIGH)
            preload_high_nibble_q <= wr_nib_q;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
            shared_pin_function_select_q <= ert_pkg::PIN_SEL_RST;
        else if (wr_en && wr_idx_q == ert_pkg::IDX_PIN_SEL)
            shared_pin_function_select_q <= wr_nib_q;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stop_cancel_pin_select_out <= 1'b0;
            event_pin_select_out <= 1'b0;
        end
        else
        begin
            stop_cancel_pin_select_out <= shared_pin_function_select_q[ert_pkg::PIN_STOP_CANCEL_INPUT_BIT];
            event_pin_select_out <= shared_pin_function_select_q[ert_pkg::PIN_EVENT_BIT];
        end
    end

    // =====================================================================
    // Count clock sources
    // =====================================================================
    logic div_tick;
    logic event_tick;
    logic count_tick;
    logic ext_sel;

    assign ext_sel = count_mode_select_q[2:0] == ert_pkg::MODE_CLK_EXT;

    ert_divider #(
        .WIDTH(ert_pkg::DIV_W)
    ) u_divider (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .halt_in(stop_mode_in),
        .sel_in(count_mode_select_q[2:0]),
        .tick_out(div_tick)
    );

    // Pin only counts while it is routed to the timer
    ert_edge_detect u_edge (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .pin_in(event_count_input_in),
        .enable_in(ext_sel && shared_pin_function_select_q[ert_pkg::PIN_EVENT_BIT]),
        .edge_sel_in(event_edge_select_q),
        .pulse_out(event_tick)
    );

    assign count_tick = ext_sel ? event_tick : div_tick;

    // =====================================================================
    // Counter and overflow flag
    // =====================================================================
    logic [7:0] eight_bit_counter_q;
    logic load_now;
    logic overflow;

    assign load_now = wr_en && wr_idx_q == ert_pkg::IDX_NIB_HIGH;
    assign overflow = count_tick && !load_now && eight_bit_counter_q == 8'hff;

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
            eight_bit_counter_q <= 8'h00;
        else if (load_now)
            eight_bit_counter_q <= {wr_nib_q, preload_low_nibble_q};
        else if (overflow)
        begin
            if (count_mode_select_q[ert_pkg::MODE_RELOAD_BIT])
                eight_bit_counter_q <= {preload_high_nibble_q, preload_low_nibble_q};
            else
                eight_bit_counter_q <= 8'h00;
        end
        else if (count_tick)
            eight_bit_counter_q <= eight_bit_counter_q + 8'h01;
    end

    // Set wins over a clearing write in the same cycle
    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
            overflow_request_flag_out <= 1'b0;
        else if (overflow)
            overflow_request_flag_out <= 1'b1;
        else if (wr_en && wr_idx_q == ert_pkg::IDX_OVF_FLAG)
            overflow_request_flag_out <= wr_nib_q[ert_pkg::OVF_FLAG_BIT];
    end

    // =====================================================================
    // Read channel
    // =====================================================================
    logic [7:0] rd_idx;
    logic [3:0] count_read_low_nibble_q;
    logic rd_take;

    assign rd_idx = reg_index(s_axi_araddr_in);
    assign rd_take = s_axi_arvalid_in && s_axi_arready_out;

    // Low half frozen at the high-half read so the pair is coherent
    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
            count_read_low_nibble_q <= 4'h0;
        else if (rd_take && rd_idx == ert_pkg::IDX_NIB_HIGH)
            count_read_low_nibble_q <= eight_bit_counter_q[3:0];
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= ert_pkg::RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= ert_pkg::RESP_OKAY;
            s_axi_rdata_out <= 32'h0000_0000;
            unique case (rd_idx)
                ert_pkg::IDX_NIB_HIGH:
                    s_axi_rdata_out <= {28'h0000000, eight_bit_counter_q[7:4]};
                ert_pkg::IDX_NIB_LOW:
                    s_axi_rdata_out <= {28'h0000000, count_read_low_nibble_q};
                ert_pkg::IDX_OVF_FLAG:
                    s_axi_rdata_out <= {31'h00000000, overflow_request_flag_out};
                ert_pkg::IDX_MODE_SEL, ert_pkg::IDX_PIN_SEL, ert_pkg::IDX_EDGE_SEL:
                    s_axi_rdata_out <= 32'h0000_0000;
                default:
                    s_axi_rresp_out <= ert_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_rvalid_out)
        begin
            if (s_axi_rready_in)
            begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
        else
            s_axi_arready_out <= 1'b1;
    end

endmodule : ert_timer

`default_nettype wire

// File: test/ert_timer_props.sv
/*
 * Checker bound into ert_timer: flag, pin selects, bus answers.
 * Assumes one clock and the raw active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module ert_timer_chk (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic overflow_request_flag_out,
    input wire logic stop_cancel_pin_select_out,
    input wire logic event_pin_select_out
);
    // ==========
    // Properties
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    AST_FLAG_RST: assert property (
        $rose(resetn_in) |-> (!overflow_request_flag_out) [*2]) else $error("flag after reset");
    AST_PIN_RST: assert property (
        $rose(resetn_in) |-> !event_pin_select_out && !stop_cancel_pin_select_out)
        else $error("pin select after reset");
    // Only a register write may clear the flag or move the routing
    AST_FLAG_CLR: assert property (
        $fell(overflow_request_flag_out) |-> (##[0:2] s_axi_bvalid_out) or $past(s_axi_bvalid_out))
        else $error("flag cleared without write");
    AST_PIN_EV: assert property (
        $changed(event_pin_select_out) |-> (##[0:2] s_axi_bvalid_out) or $past(s_axi_bvalid_out))
        else $error("event pin moved without write");
    AST_PIN_STOP_CANCEL_INPUT: assert property (
        $changed(stop_cancel_pin_select_out) |-> (##[0:2] s_axi_bvalid_out)
            or $past(s_axi_bvalid_out)) else $error("stop pin moved without write");
    AST_WR_ANS: assert property (
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            |-> ##[1:2] s_axi_bvalid_out) else $error("no write answer");
    AST_RD_ANS: assert property (
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
        else $error("no read answer");
    AST_RD_HOLD: assert property (
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data moved");
endmodule : ert_timer_chk

bind ert_timer ert_timer_chk u_chk (.*);

`default_nettype wire

// File: test/ert_event_src.sv
/*
 * Event source model driving the timer's event pin.
 * Assumes the caller picks pulse count and low gap.
 */
`timescale 1ns/10ps
`default_nettype none

module ert_event_src (
    input wire logic clk_in,
    output logic pin_out
);
    initial pin_out = 1'h0;
    // ==========
    // Pulse train, high for three clocks
    task automatic fire(input int n, input int gap);
        repeat (n)
        begin
            @(posedge clk_in);
            pin_out <= 1'h1;
            repeat (3) @(posedge clk_in);
            pin_out <= 1'h0;
            // Gap over two instruction cycles keeps both-edge mode legal
            repeat (gap) @(posedge clk_in);
        end
    endtask : fire
endmodule : ert_event_src

`default_nettype wire

// File: test/ert_timer_test.sv
/*
 * Self-checking bench for ert_timer: preload and read order, edges,
 * overflow, flag, pin selects, divider. Assumes event source and checker.
 */
`timescale 1ns/10ps
`default_nettype none

module ert_timer_test;
    localparam logic [7:0] A_FLAG = ert_pkg::IDX_OVF_FLAG << 2;
    localparam logic [7:0] A_MODE = ert_pkg::IDX_MODE_SEL << 2;
    localparam logic [7:0] A_LO = ert_pkg::IDX_NIB_LOW << 2;
    localparam logic [7:0] A_HI = ert_pkg::IDX_NIB_HIGH << 2;
    localparam logic [7:0] A_PIN = ert_pkg::IDX_PIN_SEL << 2;
    localparam logic [7:0] A_EDGE = ert_pkg::IDX_EDGE_SEL << 2;
    localparam logic [1:0] OK = ert_pkg::RESP_OKAY;
    localparam logic [3:0] M_EXT = {1'h0, ert_pkg::MODE_CLK_EXT};
    logic clk = 1'h0, resetn = 1'h0, stop = 1'h1, evpin;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, c, b;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, flag, pin_stop_cancel_input, pin_ev;
    logic [1:0] bresp, rresp;
    int err_total = 0, checks_done = 0, seed = 32'h3ab6, n, run = 0;

    always #12.5 clk = ~clk;
    ert_event_src ev (.clk_in(clk), .pin_out(evpin));
    ert_timer dut (
        .clk_sys_in(clk), .resetn_in(resetn), .stop_mode_in(stop),
        .event_count_input_in(evpin), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .overflow_request_flag_out(flag), .stop_cancel_pin_select_out(pin_stop_cancel_input),
        .event_pin_select_out(pin_ev)
    );

    // ==========
    // Checks and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [3:0] v, input logic [1:0] er);
        logic ga;
        logic gw;
        ga = 1'h0;
        gw = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {28'h0, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ga && gw))
        begin
            @(posedge clk);
            ga = ga | awready;
            gw = gw | wready;
            awvalid <= !ga;
            wvalid <= !gw;
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    // Random late rready exercises the held read answer
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        repeat ($random(seed) & 1) @(posedge clk);
        rready <= 1'h1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'h0;
        v = rdata;
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    task automatic rcnt(output logic [7:0] v);
        logic [31:0] hi;
        logic [31:0] lo;
        rd(A_HI, OK, hi);
        rd(A_LO, OK, lo);
        v = {hi[3:0], lo[3:0]};
    endtask : rcnt

    task automatic pre(input logic [7:0] v);
        wr(A_LO, v[3:0], OK);
        wr(A_HI, v[7:4], OK);
    endtask : pre

    function automatic logic [7:0] seen(input int e, input int k);
        return (e == ert_pkg::EDGE_NONE) ? 8'h00 : 8'(e == ert_pkg::EDGE_BOTH ? 2 * k : k);
    endfunction : seen

    // Divider values r..r+k-1 pass; one tick each time the tapped bits are all ones
    function automatic logic [7:0] ticks(input int r, input int k, input int tap);
        return 8'((r + k) / (2 << tap) - r / (2 << tap));
    endfunction : ticks

    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // ==========
    // Scenarios; stop held high so only events move the count, except where the divider loop releases it
    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        rd(A_FLAG, OK, d);
        chk(d, 32'h0);
        rd(8'hfc, ert_pkg::RESP_SLVERR, d);
        wr(A_HI, 4'h7, OK);
        rcnt(c);
        chk(c, 8'h70);
        wr(A_LO, 4'h5, OK);
        rcnt(c);
        chk(c, 8'h70);
        wr(A_HI, 4'ha, OK);
        rcnt(c);
        chk(c, 8'ha5);
        wr(A_HI, 4'h3, OK);
        rd(A_HI, OK, d);
        chk(d, 32'h3);
        pre(8'hc9);
        rd(A_LO, OK, d);
        chk(d, 32'h5);
        wr(A_PIN, 4'h9, OK);
        repeat (3) @(posedge clk);
        chk({pin_stop_cancel_input, pin_ev}, 2'h3);
        wr(A_EDGE, {2'h0, ert_pkg::EDGE_RISE}, OK);
        pre(8'h00);
        wr(A_MODE, M_EXT, OK);
        ev.fire(1, 90);
        rcnt(c);
        chk(c, 8'h00);
        for (int e = 0; e < 4; e++)
        begin
            wr(A_EDGE, 4'(e), OK);
            b = 8'($random(seed)) & 8'h7f;
            pre(b);
            n = 1 + ($random(seed) & 3);
            ev.fire(n, 82 + ($random(seed) & 15));
            rcnt(c);
            chk(c, b + seen(e, n));
        end
        wr(A_MODE, M_EXT | 4'h8, OK);
        repeat (ert_pkg::MODE_DELAY_CYC) @(posedge clk);
        wr(A_EDGE, 4'h1, OK);
        pre(8'hfd);
        ev.fire(3, 85);
        rcnt(c);
        chk({flag, c}, 9'h1fd);
        wr(A_FLAG, 4'h0, OK);
        rd(A_FLAG, OK, d);
        chk(d, 32'h0);
        wr(A_MODE, M_EXT, OK);
        repeat (ert_pkg::MODE_DELAY_CYC) @(posedge clk);
        pre(8'hfe);
        ev.fire(3, 85);
        rcnt(c);
        chk({flag, c}, 9'h101);
        // Three taps in turn; the divider resumes where the last run halted it
        for (int t = 4; t < 7; t++)
        begin
            wr(A_MODE, 4'(t), OK);
            repeat (ert_pkg::MODE_DELAY_CYC) @(posedge clk);
            pre(8'h00);
            n = 200 + ($random(seed) & 255);
            stop <= 1'h0;
            repeat (n) @(posedge clk);
            stop <= 1'h1;
            repeat (50) @(posedge clk);
            rcnt(c);
            chk(c, ticks(run, n, ert_pkg::DIV_TAP[t]));
            run = run + n;
        end
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED t=%0t timeout", $time);
        tally_and_finish();
    end
endmodule : ert_timer_test

`default_nettype wire
